// *** rtl/sdcmd_defs.svh ***
// constants of the command and clock-enable decoder
`ifndef SDCMD_DEFS_SVH
`define SDCMD_DEFS_SVH
`define SDCMD_NBANK 16
`define SDCMD_BL8_BEATS 4'h4
`define SDCMD_BC4_BEATS 4'h2
`define SDCMD_REF_BUSY 8'h10
`define SDCMD_ZQL_BUSY 8'h40
`define SDCMD_ZQS_BUSY 8'h10
`define SDCMD_PRE_BUSY 8'h04
`endif

// *** rtl/sdcmd_pkg.sv ***
// types of the command and clock-enable decoder
package sdcmd_pkg;
    typedef enum logic [3:0] {
        SDCMD_C_NONE = 4'h0, SDCMD_C_DES = 4'h1, SDCMD_C_NOP = 4'h2, SDCMD_C_MRS = 4'h3,
        SDCMD_C_REF = 4'h4, SDCMD_C_PRE = 4'h5, SDCMD_C_PREA = 4'h6, SDCMD_C_ACT = 4'h7,
        SDCMD_C_WR = 4'h8, SDCMD_C_RD = 4'h9, SDCMD_C_ZQL = 4'ha, SDCMD_C_ZQS = 4'hb,
        SDCMD_C_RFU = 4'hc
    } sdcmd_cmd_e;
    typedef enum logic [2:0] {
        SDCMD_S_IDLE = 3'b000, SDCMD_S_ACTIVE = 3'b001, SDCMD_S_APD = 3'b011,
        SDCMD_S_PPD = 3'b010, SDCMD_S_SREF = 3'b110
    } sdcmd_state_e;
    typedef struct packed {
        logic cs_n;
        logic act_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bg;
        logic [1:0] ba;
        logic a12;
        logic a10;
    } sdcmd_pins_s;
    typedef struct packed {
        sdcmd_cmd_e cmd;
        logic auto_pre;
        logic chop4;
        logic long_zq;
        logic [3:0] bank;
        logic [14:13] row_hi;
    } sdcmd_dec_s;
endpackage

// *** rtl/sdcmd_decoder.sv ***
// command decoder and clock-enable state logic of the memory device
`timescale 1ns/1ns
`include "sdcmd_defs.svh"
module sdcmd_decoder #(
    parameter int NBANK = `SDCMD_NBANK
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CKE,
    input wire sdcmd_pkg::sdcmd_pins_s PINS,
    input wire logic A16,
    input wire logic A15,
    input wire logic A14,
    input wire logic [13:13] A13,
    input wire logic ODT,
    input wire logic MR_OTF,
    input wire logic MR_BC4,
    output sdcmd_pkg::sdcmd_dec_s DEC,
    output logic DEC_VALID,
    output sdcmd_pkg::sdcmd_state_e STATE,
    output logic [1:0] MR_SEL_BG,
    output logic [1:0] MR_SEL_BA,
    output logic BURST_BUSY,
    output logic BURST_WRITE,
    output logic REFRESH_BUSY,
    output logic ZQ_BUSY,
    output logic ODT_EN,
    output logic IDLE,
    output logic [NBANK-1:0] BANK_OPEN
);
    // pin synchronisers: first stage read only by second
    sdcmd_pkg::sdcmd_pins_s pins_m, pins_s;
    logic cke_m, cke_s, a16_m, a16_s, a15_m, a15_s, a14_m, a14_s, a13_m, a13_s;
    logic odt_m, odt_s, otf_m, otf_s, bc4_m, bc4_s;
    logic cke_prev_q;
    sdcmd_pkg::sdcmd_state_e state_q, state_d;
    logic [NBANK-1:0] open_q;
    logic [3:0] beats_q;
    logic burst_wr_q, burst_ap_q;
    logic [3:0] burst_bank_q;
    logic [7:0] ref_cnt_q, zq_cnt_q, pre_cnt_q;
    sdcmd_pkg::sdcmd_dec_s dec_d, dec_q;
    logic dec_valid_q;
    logic [1:0] mr_bg_q, mr_ba_q;
    logic odt_en_q, idle_q, burst_busy_q, ref_busy_q, zq_busy_q;
    logic selected, busy_now, all_closed;
    logic [3:0] bank_sel;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pins_m <= '1;
            pins_s <= '1;
            {cke_m, cke_s, a16_m, a16_s, a15_m, a15_s, a14_m, a14_s} <= 8'h00;
            {a13_m, a13_s, odt_m, odt_s, otf_m, otf_s, bc4_m, bc4_s, cke_prev_q} <= 9'h000;
        end else begin
            pins_m <= PINS;
            pins_s <= pins_m;
            {cke_m, a16_m, a15_m, a14_m, a13_m} <= {CKE, A16, A15, A14, A13};
            {cke_s, a16_s, a15_s, a14_s, a13_s} <= {cke_m, a16_m, a15_m, a14_m, a13_m};
            {odt_m, otf_m, bc4_m} <= {ODT, MR_OTF, MR_BC4};
            {odt_s, otf_s, bc4_s, cke_prev_q} <= {odt_m, otf_m, bc4_m, cke_s};
        end
    end

    assign selected = !pins_s.cs_n;
    assign bank_sel = {pins_s.bg, pins_s.ba};
    assign all_closed = (open_q == '0);
    assign busy_now = (beats_q != 4'h0);

    // command decode
    always_comb begin
        dec_d = '0;
        dec_d.cmd = sdcmd_pkg::SDCMD_C_DES;
        dec_d.bank = bank_sel;
        if (selected) begin
            if (!pins_s.act_n) begin
                dec_d.cmd = sdcmd_pkg::SDCMD_C_ACT;
                dec_d.row_hi = {a15_s, a14_s};
            end else begin
                unique case ({pins_s.ras_n, pins_s.cas_n, pins_s.we_n})
                    3'b000: dec_d.cmd = sdcmd_pkg::SDCMD_C_MRS;
                    3'b001: dec_d.cmd = sdcmd_pkg::SDCMD_C_REF;
                    3'b010: dec_d.cmd = pins_s.a10 ? sdcmd_pkg::SDCMD_C_PREA
                                                   : sdcmd_pkg::SDCMD_C_PRE;
                    3'b011: dec_d.cmd = sdcmd_pkg::SDCMD_C_RFU;
                    3'b100: dec_d.cmd = sdcmd_pkg::SDCMD_C_WR;
                    3'b101: dec_d.cmd = sdcmd_pkg::SDCMD_C_RD;
                    3'b110: begin
                        dec_d.cmd = pins_s.a10 ? sdcmd_pkg::SDCMD_C_ZQL
                                               : sdcmd_pkg::SDCMD_C_ZQS;
                        dec_d.long_zq = pins_s.a10;
                    end
                    3'b111: dec_d.cmd = sdcmd_pkg::SDCMD_C_NOP;
                endcase
                dec_d.auto_pre = pins_s.a10 && (dec_d.cmd == sdcmd_pkg::SDCMD_C_WR
                                 || dec_d.cmd == sdcmd_pkg::SDCMD_C_RD);
                dec_d.chop4 = otf_s ? !pins_s.a12 : bc4_s;
            end
        end
        if (!cke_prev_q || (state_q != sdcmd_pkg::SDCMD_S_IDLE
                            && state_q != sdcmd_pkg::SDCMD_S_ACTIVE)) begin
            dec_d.cmd = sdcmd_pkg::SDCMD_C_NONE;
        end
    end

    // cke state machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            sdcmd_pkg::SDCMD_S_IDLE, sdcmd_pkg::SDCMD_S_ACTIVE: begin
                if (cke_prev_q && !cke_s) begin
                    if (!selected) begin
                        state_d = (all_closed && !busy_now) ? sdcmd_pkg::SDCMD_S_PPD
                                                            : sdcmd_pkg::SDCMD_S_APD;
                    end else if (dec_d.cmd == sdcmd_pkg::SDCMD_C_REF && all_closed) begin
                        state_d = sdcmd_pkg::SDCMD_S_SREF;
                    end
                end else begin
                    state_d = all_closed ? sdcmd_pkg::SDCMD_S_IDLE : sdcmd_pkg::SDCMD_S_ACTIVE;
                end
            end
            sdcmd_pkg::SDCMD_S_APD, sdcmd_pkg::SDCMD_S_PPD, sdcmd_pkg::SDCMD_S_SREF: begin
                if (!cke_prev_q && cke_s && !selected) begin
                    state_d = all_closed ? sdcmd_pkg::SDCMD_S_IDLE : sdcmd_pkg::SDCMD_S_ACTIVE;
                end
            end
            default: state_d = sdcmd_pkg::SDCMD_S_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= sdcmd_pkg::SDCMD_S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            dec_q <= '0;
            dec_valid_q <= 1'b0;
            mr_bg_q <= 2'h0;
            mr_ba_q <= 2'h0;
        end else begin
            dec_q <= dec_d;
            dec_valid_q <= dec_d.cmd != sdcmd_pkg::SDCMD_C_NONE
                           && dec_d.cmd != sdcmd_pkg::SDCMD_C_DES;
            if (dec_d.cmd == sdcmd_pkg::SDCMD_C_MRS) begin
                mr_bg_q <= pins_s.bg;
                mr_ba_q <= pins_s.ba;
            end
        end
    end

    // bank open tracking, auto-precharge closes at burst end
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            open_q <= '0;
        end else begin
            if (busy_now && beats_q == 4'h1 && burst_ap_q) begin
                open_q[burst_bank_q] <= 1'b0;
            end
            unique case (dec_d.cmd)
                sdcmd_pkg::SDCMD_C_ACT: open_q[bank_sel] <= 1'b1;
                sdcmd_pkg::SDCMD_C_PRE: open_q[bank_sel] <= 1'b0;
                sdcmd_pkg::SDCMD_C_PREA: open_q <= '0;
                default: ;
            endcase
        end
    end

    // burst engine: new read/write ignored until running burst finishes
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            beats_q <= 4'h0;
            burst_wr_q <= 1'b0;
            burst_ap_q <= 1'b0;
            burst_bank_q <= 4'h0;
            burst_busy_q <= 1'b0;
        end else if (!busy_now && (dec_d.cmd == sdcmd_pkg::SDCMD_C_WR
                                   || dec_d.cmd == sdcmd_pkg::SDCMD_C_RD)) begin
            beats_q <= dec_d.chop4 ? `SDCMD_BC4_BEATS : `SDCMD_BL8_BEATS;
            burst_wr_q <= dec_d.cmd == sdcmd_pkg::SDCMD_C_WR;
            burst_ap_q <= dec_d.auto_pre;
            burst_bank_q <= bank_sel;
            burst_busy_q <= 1'b1;
        end else if (busy_now) begin
            beats_q <= beats_q - 4'h1;
            burst_busy_q <= beats_q != 4'h1;
        end
    end

    // refresh, calibration and precharge timers
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ref_cnt_q <= 8'h00;
            zq_cnt_q <= 8'h00;
            pre_cnt_q <= 8'h00;
            ref_busy_q <= 1'b0;
            zq_busy_q <= 1'b0;
        end else begin
            if (state_q == sdcmd_pkg::SDCMD_S_APD || state_q == sdcmd_pkg::SDCMD_S_PPD) begin
                ref_cnt_q <= 8'h00;
                ref_busy_q <= 1'b0;
            end else if (dec_d.cmd == sdcmd_pkg::SDCMD_C_REF && cke_s) begin
                ref_cnt_q <= `SDCMD_REF_BUSY;
                ref_busy_q <= 1'b1;
            end else if (ref_cnt_q != 8'h00) begin
                ref_cnt_q <= ref_cnt_q - 8'h01;
                ref_busy_q <= ref_cnt_q != 8'h01;
            end
            if (dec_d.cmd == sdcmd_pkg::SDCMD_C_ZQL || dec_d.cmd == sdcmd_pkg::SDCMD_C_ZQS) begin
                zq_cnt_q <= dec_d.long_zq ? `SDCMD_ZQL_BUSY : `SDCMD_ZQS_BUSY;
                zq_busy_q <= 1'b1;
            end else if (zq_cnt_q != 8'h00) begin
                zq_cnt_q <= zq_cnt_q - 8'h01;
                zq_busy_q <= zq_cnt_q != 8'h01;
            end
            if (dec_d.cmd == sdcmd_pkg::SDCMD_C_PRE || dec_d.cmd == sdcmd_pkg::SDCMD_C_PREA) begin
                pre_cnt_q <= `SDCMD_PRE_BUSY;
            end else if (pre_cnt_q != 8'h00) begin
                pre_cnt_q <= pre_cnt_q - 8'h01;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            odt_en_q <= 1'b0;
            idle_q <= 1'b0;
        end else begin
            odt_en_q <= odt_s && state_d != sdcmd_pkg::SDCMD_S_SREF;
            idle_q <= state_d == sdcmd_pkg::SDCMD_S_IDLE && !busy_now && cke_s
                      && ref_cnt_q == 8'h00 && zq_cnt_q == 8'h00
                      && pre_cnt_q == 8'h00 && dec_d.cmd <= sdcmd_pkg::SDCMD_C_DES;
        end
    end

    assign DEC = dec_q;
    assign DEC_VALID = dec_valid_q;
    assign STATE = state_q;
    assign MR_SEL_BG = mr_bg_q;
    assign MR_SEL_BA = mr_ba_q;
    assign BURST_BUSY = burst_busy_q;
    assign BURST_WRITE = burst_wr_q;
    assign REFRESH_BUSY = ref_busy_q;
    assign ZQ_BUSY = zq_busy_q;
    assign ODT_EN = odt_en_q;
    assign IDLE = idle_q;
    assign BANK_OPEN = open_q;

    property p_pd_no_refresh;
        @(posedge MCLK) disable iff (!RST_N)
        (state_q == sdcmd_pkg::SDCMD_S_PPD) |=> (ref_cnt_q == 8'h00);
    endproperty
    a_pd_no_refresh: assert property (p_pd_no_refresh) else $error("refresh in power-down");
    property p_odt_sref;
        @(posedge MCLK) disable iff (!RST_N)
        (state_q == sdcmd_pkg::SDCMD_S_SREF) |-> !odt_en_q;
    endproperty
    a_odt_sref: assert property (p_odt_sref) else $error("odt on in self refresh");
    sequence s_exit_edge;
        !cke_prev_q && cke_s && pins_s.cs_n;
    endsequence
    property p_lp_exit;
        @(posedge MCLK) disable iff (!RST_N)
        (state_q == sdcmd_pkg::SDCMD_S_PPD || state_q == sdcmd_pkg::SDCMD_S_SREF) ##0 s_exit_edge
        |=> (state_q == sdcmd_pkg::SDCMD_S_IDLE || state_q == sdcmd_pkg::SDCMD_S_ACTIVE);
    endproperty
    a_lp_exit: assert property (p_lp_exit) else $error("low-power exit missed");
    property p_lp_hold;
        @(posedge MCLK) disable iff (!RST_N)
        (state_q == sdcmd_pkg::SDCMD_S_APD && !cke_s) |=> (state_q == sdcmd_pkg::SDCMD_S_APD);
    endproperty
    a_lp_hold: assert property (p_lp_hold) else $error("power-down left with cke low");
    property p_apd_entry;
        @(posedge MCLK) disable iff (!RST_N)
        (!all_closed && cke_prev_q && !cke_s && !selected && state_q == sdcmd_pkg::SDCMD_S_ACTIVE)
        |=> (state_q == sdcmd_pkg::SDCMD_S_APD);
    endproperty
    a_apd_entry: assert property (p_apd_entry) else $error("active power-down not entered");
    property p_sref_entry;
        @(posedge MCLK) disable iff (!RST_N)
        (dec_d.cmd == sdcmd_pkg::SDCMD_C_REF && cke_prev_q && !cke_s && all_closed)
        |=> (state_q == sdcmd_pkg::SDCMD_S_SREF);
    endproperty
    a_sref_entry: assert property (p_sref_entry) else $error("self refresh not entered");

    property p_burst_len;
        @(posedge MCLK) disable iff (!RST_N)
        (!busy_now && dec_d.cmd == sdcmd_pkg::SDCMD_C_RD && !dec_d.chop4)
        |=> busy_now [*4] ##1 !busy_now;
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("burst-8 length wrong");

    property p_deselect;
        @(posedge MCLK) disable iff (!RST_N)
        pins_s.cs_n |=> !dec_valid_q;
    endproperty
    a_deselect: assert property (p_deselect) else $error("command taken while deselected");

    property p_zq_long;
        @(posedge MCLK) disable iff (!RST_N)
        (dec_d.cmd == sdcmd_pkg::SDCMD_C_ZQL) |=> ZQ_BUSY ##0 dec_q.long_zq;
    endproperty
    a_zq_long: assert property (p_zq_long) else $error("long calibration not decoded");

    property p_idle;
        @(posedge MCLK) disable iff (!RST_N)
        idle_q |-> (open_q == '0) && !busy_now;
    endproperty
    a_idle: assert property (p_idle) else $error("idle with bank open or burst");
endmodule

// *** test/sdcmd_ctrl_model.sv ***
// controller-side model that drives the decoder's command pins
`timescale 1ns/1ns
module sdcmd_ctrl_model #(
    parameter int CKE_HOLD = 3
) (
    input wire logic mclk,
    output logic cke,
    output sdcmd_pkg::sdcmd_pins_s pins,
    output logic a16,
    output logic a15,
    output logic a14,
    output logic [13:13] a13,
    output logic odt
);
    // shared balls carry the command fields
    assign a16 = pins.ras_n;
    assign a15 = pins.cas_n;
    assign a14 = pins.we_n;
    initial begin
        cke = 1'b0;
        pins = '1;
        a13 = 1'b0;
        odt = 1'b0;
    end
    // deselect each edge; released lines flip so no stale level passes
    task automatic idle(input int n);
        sdcmd_pkg::sdcmd_pins_s p;
        repeat (n) begin
            @(posedge mclk);
            p = ~pins;
            p.cs_n = 1'b1;
            pins <= p;
            a13 <= ~a13;
        end
    endtask
    // one command for one cycle, never the no-operation code
    task automatic issue(input sdcmd_pkg::sdcmd_pins_s p);
        @(posedge mclk);
        pins <= p;
        idle(1);
    endtask
    // clock-enable change on the clock edge, level then held
    task automatic cke_step(input logic lvl, input sdcmd_pkg::sdcmd_pins_s p);
        @(posedge mclk);
        cke <= lvl;
        pins <= p;
        idle(CKE_HOLD);
    endtask
    task automatic set_odt(input logic v);
        @(posedge mclk);
        odt <= v;
    endtask
endmodule

// *** test/sdram_command_cke_decoder_tb.sv ***
// self-checking bench of the command and clock-enable decoder
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module sdram_command_cke_decoder_tb;
    localparam logic [4:0] RD = 5'h0d, WR = 5'h0c, ZQ = 5'h0e, RF = 5'h09, PR = 5'h0a;
    localparam sdcmd_pkg::sdcmd_pins_s DES = 11'h555;
    logic mclk, rst_n, mr_otf, mr_bc4, cke, odt, a16, a15, a14;
    logic [13:13] a13;
    sdcmd_pkg::sdcmd_pins_s pins;
    sdcmd_pkg::sdcmd_dec_s dec;
    sdcmd_pkg::sdcmd_state_e state;
    logic dec_valid, burst_busy, burst_write, refresh_busy, zq_busy, odt_en, idle_st;
    logic [1:0] mr_bg, mr_ba;
    logic [15:0] bank_open;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    sdcmd_decoder dut (
        .MCLK(mclk), .RST_N(rst_n), .CKE(cke), .PINS(pins), .A16(a16), .A15(a15),
        .A14(a14), .A13(a13), .ODT(odt), .MR_OTF(mr_otf), .MR_BC4(mr_bc4), .DEC(dec),
        .DEC_VALID(dec_valid), .STATE(state), .MR_SEL_BG(mr_bg), .MR_SEL_BA(mr_ba),
        .BURST_BUSY(burst_busy), .BURST_WRITE(burst_write), .REFRESH_BUSY(refresh_busy),
        .ZQ_BUSY(zq_busy), .ODT_EN(odt_en), .IDLE(idle_st), .BANK_OPEN(bank_open)
    );
    sdcmd_ctrl_model ctrl (
        .mclk(mclk), .cke(cke), .pins(pins), .a16(a16), .a15(a15), .a14(a14),
        .a13(a13), .odt(odt)
    );
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    function automatic sdcmd_pkg::sdcmd_pins_s mk(input logic [4:0] c, input logic [3:0] bk,
        input logic a12, input logic a10);
        return {c, bk, a12, a10};
    endfunction
    task automatic wait_dec(input sdcmd_pkg::sdcmd_cmd_e exp);
        int n;
        n = 0;
        #1;
        while (dec_valid !== 1'b1 && n < 6) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("dec_valid", 1'b1, dec_valid)
        `CHK("dec_cmd", exp, dec.cmd)
    endtask
    task automatic wait_state(input sdcmd_pkg::sdcmd_state_e exp);
        int n;
        n = 0;
        #1;
        while (state !== exp && n < 10) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("state", exp, state)
    endtask
    task automatic t_rw();
        int n;
        logic [3:0] i;
        logic chop;
        for (int k = 0; k < 10; k++) begin
            i = 4'(k);
            chop = (k < 8) ? !i[2] : (k == 8);
            @(posedge mclk);
            mr_otf <= (k < 8);
            mr_bc4 <= (k != 9);
            ctrl.issue(mk(i[0] ? RD : WR, {i[2:0], 1'b1}, i[2], i[1]));
            wait_dec(i[0] ? sdcmd_pkg::SDCMD_C_RD : sdcmd_pkg::SDCMD_C_WR);
            `CHK("auto_pre", i[1], dec.auto_pre)
            `CHK("chop4", chop, dec.chop4)
            `CHK("bank", {i[2:0], 1'b1}, dec.bank)
            n = 0;
            while (burst_busy === 1'b1 && n < 10) begin
                n++;
                @(posedge mclk);
                #1;
                if (n == 1) begin
                    `CHK("pulse", 1'b0, dec_valid)
                    `CHK("burst_write", !i[0], burst_write)
                end
            end
            `CHK("burst_len", (chop ? 2 : 4), n)
        end
        $display("test read_write done");
    endtask
    task automatic t_zq();
        for (int k = 0; k < 2; k++) begin
            ctrl.issue(mk(ZQ, 4'h9, 1'b1, k[0]));
            wait_dec(k[0] ? sdcmd_pkg::SDCMD_C_ZQL : sdcmd_pkg::SDCMD_C_ZQS);
            `CHK("long_zq", k[0], dec.long_zq)
            repeat ((k[0] ? 64 : 16) - 2) @(posedge mclk);
            #1;
            `CHK("zq_busy", 1'b1, zq_busy)
            repeat (3) @(posedge mclk);
            #1;
            `CHK("zq_busy", 1'b0, zq_busy)
        end
        $display("test zq done");
    endtask
    task automatic t_cs();
        int n;
        n = 0;
        ctrl.issue(mk(RD, 4'h2, 1'b1, 1'b0));
        wait_dec(sdcmd_pkg::SDCMD_C_RD);
        repeat (8) begin
            ctrl.idle(1);
            #1;
            if (dec_valid !== 1'b0) n++;
        end
        `CHK("stray_cmds", 0, n)
        $display("test deselect done");
    endtask
    task automatic t_act();
        ctrl.issue(mk(5'h05, 4'h6, 1'b0, 1'b0));
        wait_dec(sdcmd_pkg::SDCMD_C_ACT);
        `CHK("row_hi", 2'b01, dec.row_hi)
        `CHK("bank", 4'h6, dec.bank)
        ctrl.issue(mk(5'h02, 4'h3, 1'b1, 1'b1));
        wait_dec(sdcmd_pkg::SDCMD_C_ACT);
        `CHK("row_hi", 2'b10, dec.row_hi)
        ctrl.idle(2);
        #1;
        `CHK("bank_open", 16'h0048, bank_open)
        ctrl.issue(mk(5'h08, 4'h9, 1'b0, 1'b0));
        wait_dec(sdcmd_pkg::SDCMD_C_MRS);
        ctrl.idle(2);
        #1;
        `CHK("mr_bg", 2'b10, mr_bg)
        `CHK("mr_ba", 2'b01, mr_ba)
        $display("test activate done");
    endtask
    task automatic t_power();
        ctrl.cke_step(1'b0, DES);
        wait_state(sdcmd_pkg::SDCMD_S_APD);
        ctrl.set_odt(1'b1);
        ctrl.idle(4);
        #1;
        `CHK("state", sdcmd_pkg::SDCMD_S_APD, state)
        `CHK("refresh_busy", 1'b0, refresh_busy)
        `CHK("odt_en", 1'b1, odt_en)
        ctrl.cke_step(1'b1, DES);
        wait_state(sdcmd_pkg::SDCMD_S_ACTIVE);
        ctrl.issue(mk(PR, 4'h0, 1'b0, 1'b1));
        wait_dec(sdcmd_pkg::SDCMD_C_PREA);
        ctrl.idle(8);
        #1;
        `CHK("bank_open", 16'h0000, bank_open)
        `CHK("idle", 1'b1, idle_st)
        ctrl.cke_step(1'b0, DES);
        wait_state(sdcmd_pkg::SDCMD_S_PPD);
        ctrl.cke_step(1'b1, DES);
        wait_state(sdcmd_pkg::SDCMD_S_IDLE);
        ctrl.idle(4);
        ctrl.issue(mk(RF, 4'h0, 1'b0, 1'b0));
        wait_dec(sdcmd_pkg::SDCMD_C_REF);
        `CHK("refresh_busy", 1'b1, refresh_busy)
        `CHK("idle", 1'b0, idle_st)
        repeat (17) @(posedge mclk);
        #1;
        `CHK("refresh_busy", 1'b0, refresh_busy)
        ctrl.cke_step(1'b0, mk(RF, 4'h0, 1'b0, 1'b0));
        wait_state(sdcmd_pkg::SDCMD_S_SREF);
        `CHK("odt_en", 1'b0, odt_en)
        ctrl.cke_step(1'b1, DES);
        wait_state(sdcmd_pkg::SDCMD_S_IDLE);
        ctrl.set_odt(1'b0);
        $display("test power done");
    endtask
    task automatic t_midreset();
        ctrl.issue(mk(RD, 4'h1, 1'b1, 1'b0));
        wait_dec(sdcmd_pkg::SDCMD_C_RD);
        @(posedge mclk);
        rst_n <= 1'b0;
        #1;
        `CHK("burst_busy", 1'b0, burst_busy)
        `CHK("dec_valid", 1'b0, dec_valid)
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        ctrl.idle(4);
        ctrl.issue(mk(RD, 4'h1, 1'b1, 1'b0));
        wait_dec(sdcmd_pkg::SDCMD_C_RD);
        $display("test mid_reset done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            $display("ERROR timeout expected 0 seen 1");
            complete_run();
        end
    end
    initial begin
        rst_n = 1'b0;
        mr_otf = 1'b1;
        mr_bc4 = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        `CHK("state", sdcmd_pkg::SDCMD_S_IDLE, state)
        `CHK("dec_cmd", sdcmd_pkg::SDCMD_C_NONE, dec.cmd)
        `CHK("bank_open", 16'h0000, bank_open)
        $display("test reset done");
        @(posedge mclk);
        rst_n <= 1'b1;
        ctrl.cke_step(1'b1, DES);
        t_rw();
        t_zq();
        t_cs();
        t_act();
        t_power();
        t_midreset();
        complete_run();
    end
endmodule
